// *** hw/ascq_pkg.sv ***
// Behaviour
// - every control register write starts a fresh conversion sequence, with the new settings only when byte 0 is strobed
// - a control write during a running sequence aborts it and clears all done flags
// - the control register may be read or written at any moment
// - scan bit 0 runs one sequence and stops; 1 repeats sequences continuously
// - multichannel bit 0: every conversion samples the one selected input
// - multichannel bit 1: four or eight inputs converted in turn from selected group
// - length bit 0 gives four conversions, 1 gives eight, in both channel modes
// - scan, multichannel and length bits together select one of eight modes
// - codes 0-7 analog inputs, 8-11 reserved, 12-14 references and midpoint, 15 test
// - single-channel results fill slots 0-3 or 0-7
// - mode and channel bits reset to zero; the upper nine bits are unused
// - sequence-done flag set at first sequence end; cleared by a control write
// - each slot-done flag is set on its conversion, held until its result is read
// - the next-slot pointer shows the slot to be written next
package ascq_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL    = 8'h00;
	localparam logic [7:0] OFF_STATUS  = 8'h04;
	localparam logic [7:0] OFF_IRQ_ST  = 8'h08;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h0c;
	localparam logic [7:0] OFF_IRQ_EN  = 8'h10;
	localparam logic [7:0] OFF_RES     = 8'h20;
	localparam logic [7:0] OFF_RES_END = 8'h3c;
	localparam int         WORD_SHIFT  = 2;
	// field layout
	localparam int CTRL_W        = 7;
	localparam int STAT_SCF_BIT  = 15;
	localparam int STAT_CTR_LSB  = 8;
	localparam int STAT_CCF_LSB  = 0;
	localparam int IRQ_W         = 2;
	localparam int IRQ_SEQ_BIT   = 0;
	localparam int IRQ_SLOT_BIT  = 1;
	localparam logic [2:0] LAST_OF_FOUR  = 3'h3;
	localparam logic [2:0] LAST_OF_EIGHT = 3'h7;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       scan;
		logic       multi_channel_sel;
		logic       eight_conversion_sel;
		logic [3:0] channel_select_field;
	} ascq_ctrl_t;

	localparam ascq_ctrl_t CTRL_RESET = '0;

	// gray codes along idle -> issue -> wait -> issue
	typedef enum logic [1:0] {
		S_IDLE  = 2'h0,
		S_ISSUE = 2'h1,
		S_WAIT  = 2'h3
	} ascq_state_t;

	// input code for the slot about to be converted
	function automatic logic [3:0] chan_for(ascq_ctrl_t c, logic [2:0] slot);
		if (!c.multi_channel_sel)
			return c.channel_select_field;
		if (c.eight_conversion_sel)
			return {c.channel_select_field[3], slot};
		return {c.channel_select_field[3:2], slot[1:0]};
	endfunction : chan_for

	function automatic logic [2:0] last_slot(ascq_ctrl_t c);
		return c.eight_conversion_sel ? LAST_OF_EIGHT : LAST_OF_FOUR;
	endfunction : last_slot

	function automatic logic is_result(logic [7:0] a);
		return a >= OFF_RES && a <= OFF_RES_END;
	endfunction : is_result

	function automatic logic [2:0] res_idx(logic [7:0] a);
		logic [7:0] off;
		off = 8'(a - OFF_RES) >> WORD_SHIFT;
		return off[2:0];
	endfunction : res_idx

	function automatic logic addr_ok(logic [7:0] a);
		return a[1:0] == 2'h0 && (a <= OFF_IRQ_EN || is_result(a));
	endfunction : addr_ok
endpackage : ascq_pkg

// *** hw/ascq_reg_if.sv ***
`timescale 1ns/1ps
// register requests from the bus front end to the register file
interface ascq_reg_if;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  waddr;
	logic [7:0]  raddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic [31:0] rdata;
	logic        rd_ack;
	modport slave (output wr_en, rd_en, waddr, raddr, wdata, wstrb, input rdata, rd_ack);
	modport regs  (input wr_en, rd_en, waddr, raddr, wdata, wstrb, output rdata, rd_ack);
endinterface : ascq_reg_if

// *** hw/ascq_result_mem.sv ***
`timescale 1ns/1ps
// result slots; read data come out of a register one cycle after the address
module ascq_result_mem #(
	parameter int W  = 10,
	parameter int D  = 8,
	parameter int AW = 3
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	// write port
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// read port
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [W-1:0]        rd;
	} ascq_mem_t;

	ascq_mem_t q, d;

	// write and read may hit one slot together; the read returns the old word
	always_comb begin
		d = q;
		d.rd = q.mem[raddr];
		if (we)
			d.mem[waddr] = wdata;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign rdata = q.rd;
endmodule : ascq_result_mem

// *** hw/ascq_axil_slave.sv ***
`timescale 1ns/1ps
// axi4-lite front end: one write and one read in flight, all outputs registered
module ascq_axil_slave (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// write channels
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// read channels
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// register side
	ascq_reg_if.slave        rif
);
	typedef struct packed {
		logic        awready, wready, arready, bvalid, rvalid;
		logic [1:0]  bresp, rresp;
		logic [31:0] rdata;
		logic        have_aw, have_w, busy, wr_en, rd_en;
		logic [7:0]  waddr, raddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
	} ascq_slv_t;

	ascq_slv_t q, d;

	// address and data may arrive in either order; the write fires once both are held
	always_comb begin
		d = q;
		d.wr_en = 1'b0;
		d.rd_en = 1'b0;
		if (s_axi_awvalid && q.awready) begin
			d.have_aw = 1'b1;
			d.waddr   = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.have_w = 1'b1;
			d.wdata  = s_axi_wdata;
			d.wstrb  = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.have_aw && q.have_w && !q.bvalid) begin
			d.wr_en   = 1'b1;
			d.bvalid  = 1'b1;
			d.bresp   = ascq_pkg::addr_ok(q.waddr) ? ascq_pkg::RESP_OKAY : ascq_pkg::RESP_SLVERR;
			d.have_aw = 1'b0;
			d.have_w  = 1'b0;
		end
		d.awready = !d.have_aw && !d.bvalid;
		d.wready  = !d.have_w && !d.bvalid;
		// read: request, wait one cycle for the registered data, then answer
		if (s_axi_arvalid && q.arready) begin
			d.busy  = 1'b1;
			d.raddr = s_axi_araddr;
			d.rd_en = 1'b1;
		end
		if (rif.rd_ack) begin
			d.rvalid = 1'b1;
			d.rdata  = ascq_pkg::addr_ok(q.raddr) ? rif.rdata : '0;
			d.rresp  = ascq_pkg::addr_ok(q.raddr) ? ascq_pkg::RESP_OKAY : ascq_pkg::RESP_SLVERR;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
			d.busy   = 1'b0;
		end
		d.arready = !d.busy;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else if (ce)
			q <= d;
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.wready;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign s_axi_rvalid  = q.rvalid;
	assign rif.wr_en     = q.wr_en;
	assign rif.rd_en     = q.rd_en;
	assign rif.waddr     = q.waddr;
	assign rif.raddr     = q.raddr;
	assign rif.wdata     = q.wdata;
	assign rif.wstrb     = q.wstrb;
endmodule : ascq_axil_slave

// *** hw/ascq_top.sv ***
`timescale 1ns/1ps
// conversion sequencer with its registers, result slots and interrupt
module ascq_top #(
	parameter int RES_W = 10
) (
	// clock, reset, enable
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// axi4-lite write
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	// converter core
	output logic                  conv_start,
	output logic [3:0]            conv_channel,
	output logic                  conv_abort,
	input  wire logic             conv_done,
	input  wire logic [RES_W-1:0] conv_result,
	// interrupt
	output logic                  irq
);
	typedef struct packed {
		ascq_pkg::ascq_ctrl_t  ctrl;
		ascq_pkg::ascq_state_t st;
		logic [2:0]                 next_slot_pointer;
		logic                       sequence_done_flag;
		logic [7:0]                 slot_done_flags;
		logic [ascq_pkg::IRQ_W-1:0] irq_st;
		logic [ascq_pkg::IRQ_W-1:0] irq_en;
		logic                       irq;
		logic                       conv_start;
		logic [3:0]                 conv_chan;
		logic                       conv_abort;
		logic                       rd_ack;
		logic                       rd_res;
		logic [15:0]                rreg;
	} ascq_top_t;

	ascq_top_t q, d;

	ascq_reg_if rif ();

	logic             ctrl_wr;
	logic             seq_end;
	logic             slot_wr;
	logic [15:0]      rmux;
	logic [RES_W-1:0] res_q;

	ascq_axil_slave u_slave (
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.s_axi_awaddr (s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata  (s_axi_wdata),
		.s_axi_wstrb  (s_axi_wstrb),
		.s_axi_wvalid (s_axi_wvalid),
		.s_axi_wready (s_axi_wready),
		.s_axi_bresp  (s_axi_bresp),
		.s_axi_bvalid (s_axi_bvalid),
		.s_axi_bready (s_axi_bready),
		.s_axi_araddr (s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata  (s_axi_rdata),
		.s_axi_rresp  (s_axi_rresp),
		.s_axi_rvalid (s_axi_rvalid),
		.s_axi_rready (s_axi_rready),
		.rif          (rif.slave)
	);

	// results land in the slot the pointer names
	ascq_result_mem #(.W(RES_W), .D(8), .AW(3)) u_mem (
		.ref_clk(ref_clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.we     (slot_wr),
		.waddr  (q.next_slot_pointer),
		.wdata  (conv_result),
		.raddr  (ascq_pkg::res_idx(rif.raddr)),
		.rdata  (res_q)
	);

	// request decode; a conversion finishing in a write cycle belongs to the aborted run
	assign ctrl_wr = rif.wr_en && rif.waddr == ascq_pkg::OFF_CTRL;
	assign slot_wr = q.st == ascq_pkg::S_WAIT && conv_done && !ctrl_wr;
	assign seq_end = slot_wr && q.next_slot_pointer == ascq_pkg::last_slot(q.ctrl);

	// read mux over the plain registers
	always_comb begin
		rmux = '0;
		unique case (rif.raddr)
			ascq_pkg::OFF_CTRL:   rmux[ascq_pkg::CTRL_W-1:0] = q.ctrl;
			ascq_pkg::OFF_STATUS: begin
				rmux[ascq_pkg::STAT_SCF_BIT]      = q.sequence_done_flag;
				rmux[ascq_pkg::STAT_CTR_LSB +: 3] = q.next_slot_pointer;
				rmux[ascq_pkg::STAT_CCF_LSB +: 8] = q.slot_done_flags;
			end
			ascq_pkg::OFF_IRQ_ST: rmux[ascq_pkg::IRQ_W-1:0] = q.irq_st;
			ascq_pkg::OFF_IRQ_EN: rmux[ascq_pkg::IRQ_W-1:0] = q.irq_en;
			default:              rmux = '0;
		endcase
	end

	// next state: clears first so that a set in the same cycle wins
	always_comb begin
		d = q;
		d.conv_start = 1'b0;
		d.conv_abort = 1'b0;
		d.rd_ack     = 1'b0;
		if (rif.rd_en) begin
			d.rd_ack = 1'b1;
			d.rd_res = ascq_pkg::is_result(rif.raddr);
			d.rreg   = rmux;
			// a misaligned result address is refused and must not clear a flag
			if (ascq_pkg::is_result(rif.raddr) && ascq_pkg::addr_ok(rif.raddr))
				d.slot_done_flags[ascq_pkg::res_idx(rif.raddr)] = 1'b0;
		end
		if (rif.wr_en && rif.waddr == ascq_pkg::OFF_IRQ_CLR)
			d.irq_st = q.irq_st & ~rif.wdata[ascq_pkg::IRQ_W-1:0];
		if (rif.wr_en && rif.waddr == ascq_pkg::OFF_IRQ_EN && rif.wstrb[0])
			d.irq_en = rif.wdata[ascq_pkg::IRQ_W-1:0];
		if (ctrl_wr) begin
			if (rif.wstrb[0])
				d.ctrl = ascq_pkg::ascq_ctrl_t'(rif.wdata[ascq_pkg::CTRL_W-1:0]);
			d.conv_abort         = q.st != ascq_pkg::S_IDLE;
			d.sequence_done_flag = 1'b0;
			d.slot_done_flags    = '0;
			d.next_slot_pointer  = '0;
			d.st                 = ascq_pkg::S_ISSUE;
		end else begin
			unique case (q.st)
				ascq_pkg::S_IDLE: d.st = ascq_pkg::S_IDLE;
				ascq_pkg::S_ISSUE: begin
					d.conv_start = 1'b1;
					d.conv_chan  = ascq_pkg::chan_for(q.ctrl, q.next_slot_pointer);
					d.st         = ascq_pkg::S_WAIT;
				end
				ascq_pkg::S_WAIT: begin
					if (slot_wr) begin
						d.slot_done_flags[q.next_slot_pointer] = 1'b1;
						d.irq_st[ascq_pkg::IRQ_SLOT_BIT]       = 1'b1;
						d.next_slot_pointer = 3'(q.next_slot_pointer + 3'h1);
						d.st                = ascq_pkg::S_ISSUE;
					end
					if (seq_end) begin
						d.sequence_done_flag            = 1'b1;
						d.irq_st[ascq_pkg::IRQ_SEQ_BIT] = 1'b1;
						d.next_slot_pointer             = '0;
						d.st = q.ctrl.scan ? ascq_pkg::S_ISSUE : ascq_pkg::S_IDLE;
					end
				end
				default: d.st = ascq_pkg::S_IDLE;
			endcase
		end
		d.irq = |(d.irq_st & d.irq_en);
	end

	// reset leaves every mode bit at zero and the sequencer idle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			q <= '0;
		else if (ce)
			q <= d;
	end

	// memory data only line up with the ack one cycle after the request
	assign rif.rdata  = q.rd_res ? 32'(res_q) : 32'(q.rreg);
	assign rif.rd_ack = q.rd_ack;
	assign conv_start   = q.conv_start;
	assign conv_channel = q.conv_chan;
	assign conv_abort   = q.conv_abort;
	assign irq          = q.irq;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n || !ce);

	logic [2:0] prev_slot;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			prev_slot <= '0;
		else if (ce)
			prev_slot <= q.next_slot_pointer;
	end

	wr_start_a: assert property (ctrl_wr |=> q.st == ascq_pkg::S_ISSUE ##1 conv_start)
		else $error("control write did not start a sequence");
	abort_clear_a: assert property (ctrl_wr |=> !q.sequence_done_flag && q.slot_done_flags == '0)
		else $error("control write left done flags set");
	rd_answer_a: assert property (rif.rd_en |=> rif.rd_ack)
		else $error("register read not answered next cycle");
	single_stop_a: assert property (seq_end && !q.ctrl.scan |=> q.st == ascq_pkg::S_IDLE)
		else $error("single sequence did not stop");
	repeat_scan_a: assert property (seq_end && q.ctrl.scan |=> q.st == ascq_pkg::S_ISSUE
		&& q.next_slot_pointer == 3'h0)
		else $error("continuous sequence did not restart at slot zero");
	fixed_chan_a: assert property (conv_start && !q.ctrl.multi_channel_sel
		|-> conv_channel == q.ctrl.channel_select_field)
		else $error("single-channel mode sampled the wrong input");
	multi_chan_a: assert property (conv_start && q.ctrl.multi_channel_sel
		|-> conv_channel[1:0] == q.next_slot_pointer[1:0])
		else $error("multichannel input does not follow the slot");
	seq_len_a: assert property (slot_wr && q.next_slot_pointer == ascq_pkg::LAST_OF_FOUR
		&& !q.ctrl.eight_conversion_sel |-> seq_end)
		else $error("four-conversion sequence ran past slot three");
	done_flags_a: assert property (slot_wr |=> q.slot_done_flags[prev_slot])
		else $error("slot done flag not set");
	scf_set_a: assert property (seq_end |=> q.sequence_done_flag)
		else $error("sequence done flag not set at sequence end");

	single_run_c: cover property (ctrl_wr ##[1:200] seq_end && !q.ctrl.scan);
	scan_run_c:   cover property (seq_end && q.ctrl.scan ##[1:200] seq_end);
	abort_c:      cover property (ctrl_wr && q.st == ascq_pkg::S_WAIT);
endmodule : ascq_top

// *** verification/ascq_core_model.sv ***
`timescale 1ns/1ps
// converter core stand-in: answers each start after lat cycles, drops it on abort
module ascq_core_model (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// requests from the sequencer
	input  wire logic       conv_start,
	input  wire logic [3:0] conv_channel,
	input  wire logic       conv_abort,
	// bench knobs: answer latency and upper result bits
	input  wire logic [7:0] lat,
	input  wire logic [5:0] salt,
	// answer
	output logic            conv_done,
	output logic [9:0]      conv_result
);
	logic       busy;
	logic [7:0] cnt;
	logic [3:0] ch;

	// result carries the sampled channel so slots can be told apart;
	// between answers the bus toggles so stale data never looks valid
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			ch <= 4'h0;
			conv_done <= 1'b0;
			conv_result <= 10'h000;
		end else begin
			conv_done <= 1'b0;
			conv_result <= ~conv_result;
			if (conv_abort) begin
				busy <= 1'b0; // an aborted conversion is never answered
			end else if (conv_start) begin
				busy <= 1'b1;
				ch <= conv_channel;
				cnt <= lat;
			end else if (busy) begin
				if (cnt <= 8'h01) begin
					busy <= 1'b0;
					conv_done <= 1'b1;
					conv_result <= {salt, ch};
				end else begin
					cnt <= cnt - 8'h01;
				end
			end
		end
	end
endmodule : ascq_core_model

// *** verification/adc_sequence_control_bench.sv ***
`timescale 1ns/1ps
// bench: bus tasks, a queue of observed starts, expected slots worked out per mode
module adc_sequence_control_bench;
	logic        ref_clk, rst_n, ce;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        conv_start, conv_abort, conv_done, irq;
	logic [3:0]  conv_channel;
	logic [9:0]  conv_result;
	logic [7:0]  lat;
	logic [5:0]  salt;
	logic [3:0]  starts[$];
	int          miscompares, samples_checked, cycles, aborts;

	ascq_top u_ascq_top (.ref_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .conv_channel, .conv_abort,
		.conv_done, .conv_result, .irq);
	ascq_core_model u_ascq_core_model (.ref_clk, .rst_n, .conv_start, .conv_channel,
		.conv_abort, .lat, .salt, .conv_done, .conv_result);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// starts are logged mid-cycle so a queue reset at an edge never races them
	always @(negedge ref_clk) if (conv_start === 1'b1) starts.push_back(conv_channel);
	always @(negedge ref_clk) if (conv_abort === 1'b1) aborts++;

	// hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			complete_run();
		end
	end

	task complete_run;
		if (miscompares == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : chk

	// input code the sequencer must present for slot s
	function automatic logic [3:0] exp_chan(logic [6:0] c, int s);
		if (!c[5]) return c[3:0];
		if (c[4]) return {c[3], 3'(s)};
		return {c[3:2], 2'(s)};
	endfunction : exp_chan

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit ad, wd, bd;
		int n;
		ad = 0;
		wd = 0;
		bd = 0;
		n = 0;
		r = 2'h3;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!bd && n < 100) begin
			@(posedge ref_clk);
			n++;
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
			// bready stays high afterwards so a following call never lowers and raises it at once
			if (s_axi_bvalid === 1'b1) begin
				bd = 1;
				r = s_axi_bresp;
			end
		end
		chk("write answer", 32'h1, 32'(bd));
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ad, rd;
		int n;
		ad = 0;
		rd = 0;
		n = 0;
		r = 2'h3;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!rd && n < 100) begin
			@(posedge ref_clk);
			n++;
			if (!ad && s_axi_arready === 1'b1) begin
				ad = 1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid === 1'b1) begin
				rd = 1;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
		end
		chk("read answer", 32'h1, 32'(rd));
	endtask : axr

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		axr(a, d, r);
		chk("rdata", e, d);
	endtask : rdchk

	// one sequence in mode c, checked slot by slot against the expected inputs
	task automatic run_mode(input logic [6:0] c);
		logic [31:0] d;
		logic [1:0]  r;
		int          n, k;
		n = c[4] ? 8 : 4;
		lat <= 8'(1 + $urandom % 12);
		salt <= 6'($urandom);
		axw(ascq_pkg::OFF_CTRL, ($urandom & 32'hffffff80) | 32'(c), r);
		starts.delete();
		rdchk(ascq_pkg::OFF_CTRL, 32'(c));
		k = 0;
		do begin
			axr(ascq_pkg::OFF_STATUS, d, r);
			k++;
		end while (d[15] !== 1'b1 && k < 400);
		chk("done poll", 32'h1, 32'(d[15] === 1'b1));
		if (!c[6]) rdchk(ascq_pkg::OFF_STATUS, 32'h8000 | ((32'h1 << n) - 1));
		chk("count", n, (starts.size() >= n) ? n : starts.size());
		for (int s = 0; s < n; s++) begin
			chk("channel", exp_chan(c, s), starts[s]);
			rdchk(ascq_pkg::OFF_RES + 8'(4 * s), {salt, exp_chan(c, s)});
		end
		if (!c[6]) begin
			rdchk(ascq_pkg::OFF_STATUS, 32'h8000);
			repeat (40) @(posedge ref_clk);
			chk("stopped", n, starts.size());
		end else begin
			k = 0;
			while (starts.size() <= n && k < 300) begin
				@(posedge ref_clk);
				k++;
			end
			chk("restart count", 32'h1, 32'(starts.size() > n));
			chk("restart", exp_chan(c, 0), starts[n]);
		end
	endtask : run_mode

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          k;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		ce = 1'b1;
		rst_n = 1'b0;
		lat = 8'h05;
		salt = 6'h00;
		void'($urandom(65));
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// reset values and unmapped places
		rdchk(ascq_pkg::OFF_CTRL, 32'h0);
		rdchk(ascq_pkg::OFF_STATUS, 32'h0);
		rdchk(ascq_pkg::OFF_IRQ_EN, 32'h0);
		axw(8'h14, 32'h1, r);
		chk("bresp", ascq_pkg::RESP_SLVERR, r);
		axr(8'h02, d, r);
		chk("rresp", ascq_pkg::RESP_SLVERR, r);
		chk("rdata", 32'h0, d);
		// interrupt raised, masked and cleared after a one-shot sequence
		run_mode(7'h03);
		rdchk(ascq_pkg::OFF_IRQ_ST, 32'h3);
		axw(ascq_pkg::OFF_IRQ_EN, 32'h1, r);
		rdchk(ascq_pkg::OFF_IRQ_EN, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		axw(ascq_pkg::OFF_IRQ_EN, 32'h0, r);
		rdchk(ascq_pkg::OFF_IRQ_EN, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		axw(ascq_pkg::OFF_IRQ_CLR, 32'h3, r);
		rdchk(ascq_pkg::OFF_IRQ_ST, 32'h0);
		axw(ascq_pkg::OFF_IRQ_EN, 32'h3, r);
		rdchk(ascq_pkg::OFF_IRQ_EN, 32'h3);
		chk("irq", 32'h0, {31'h0, irq});
		// a rewrite mid-sequence must drop flags and pointer at once
		lat <= 8'd40;
		axw(ascq_pkg::OFF_CTRL, 32'h13, r);
		starts.delete();
		k = 0;
		while (starts.size() < 3 && k < 400) begin
			@(posedge ref_clk);
			k++;
		end
		axw(ascq_pkg::OFF_CTRL, 32'h15, r);
		rdchk(ascq_pkg::OFF_STATUS, 32'h0);
		chk("abort", 32'h1, aborts);
		run_mode(7'h15);
		// every mode twice, every channel code once
		for (int i = 0; i < 16; i++) run_mode({i[2:0], i[3:0]});
		complete_run();
	end
endmodule : adc_sequence_control_bench
